// ### rtl/intc_prio_regs.sv
// Interrupt priority fields behind an AHB-Lite slave, with per-source request gating.
//
// The implementer's own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Field code 111 gives the source level 7, the highest.
// - Field code 001 gives level 1, the lowest; codes in between map linearly.
// - Field code 000 disables the source; it never requests.
// - Unimplemented bits read zero and ignore writes.
// - UART receive priority sits at bits 14 to 12 of the first register.
// - SPI event priority sits at bits 10 to 8 of the first register.
// - SPI error priority sits at bits 6 to 4 of the first register.
// - External interrupt 1 priority at bits 2 to 0 of register two.
// - Timer4 priority at bits 14 to 12 of register three, when present.
module intc_prio_regs #(
    parameter int ADDR_W = intc_prio_pkg::HADDR_W,
    parameter bit HAS_TIMER4 = 1'b1
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic hsel_i,
    input wire logic [ADDR_W-1:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic [intc_prio_pkg::NUM_SRC-1:0] src_flag_i,
    output logic [intc_prio_pkg::NUM_SRC-1:0] src_req_o,
    output intc_prio_pkg::prio_t [intc_prio_pkg::NUM_SRC-1:0] src_level_o,
    output intc_prio_pkg::prio_t uart_rx_prio_o,
    output intc_prio_pkg::prio_t spi_event_prio_o,
    output intc_prio_pkg::prio_t spi_error_prio_o,
    output intc_prio_pkg::prio_t timer3_prio_o,
    output intc_prio_pkg::prio_t ext_int1_prio_o,
    output intc_prio_pkg::prio_t timer4_prio_o
);
    import intc_prio_pkg::*;

    // ==========================================================
    // Elaboration checks
    generate
        if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr_w
            $error("ADDR_W must lie between 4 and 32");
        end
    endgenerate

    // ==========================================================
    // AHB-Lite address and data phases
    logic addr_phase;
    logic dp_valid;
    logic dp_write;
    logic [ADDR_W-1:0] dp_addr;
    logic ap_hit;
    logic dp_hit;
    reg_idx_t ap_idx;
    reg_idx_t dp_idx;
    logic [REG_W-1:0] next_rdata;

    // Decodes a byte address to a register index; low two bits are ignored.
    function automatic logic decode(input logic [ADDR_W-1:0] a, output reg_idx_t idx);
        logic [ADDR_W-1:0] w;
        w = {a[ADDR_W-1:2], 2'h0};
        idx = IDX_PRIO_A;
        decode = 1'b1;
        if (w == ADDR_W'(OFF_PRIORITY_UART_SPI_TIMER3)) begin
            idx = IDX_PRIO_A;
        end else if (w == ADDR_W'(OFF_PRIORITY_EXTERNAL_INT1)) begin
            idx = IDX_PRIO_B;
        end else if (w == ADDR_W'(OFF_PRIORITY_TIMER4)) begin
            idx = IDX_PRIO_C;
        end else begin
            decode = 1'b0;
        end
    endfunction

    assign addr_phase = hsel_i && (htrans_i == HTRANS_NONSEQ || htrans_i == 2'h3) && hready_i;

    always_comb begin
        ap_hit = decode(haddr_i, ap_idx);
        dp_hit = decode(dp_addr, dp_idx);
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_addr <= '0;
        end else if (hready_i) begin
            dp_valid <= addr_phase;
            dp_write <= hwrite_i;
            dp_addr <= haddr_i;
        end
    end

    // Every transfer completes without wait states and with an OKAY answer.
    assign hreadyout_o = 1'b1;
    assign hresp_o = HRESP_OKAY;

    // ==========================================================
    // Priority fields
    prio_t prio_q [NUM_SRC];
    prio_t prio_d [NUM_SRC];
    prio_t prio_view [NUM_SRC];
    logic prio_we [NUM_SRC];

    genvar gi;
    generate
        for (gi = 0; gi < NUM_SRC; gi++) begin : g_field
            localparam bit PRESENT = (gi != SRC_TIMER4) || HAS_TIMER4;
            assign prio_we[gi] = dp_valid && dp_write && dp_hit && dp_idx == FIELD_REG[gi];
            assign prio_d[gi] = hwdata_i[FIELD_LSB[gi] +: PRIO_W];
            // A write still in its data phase is forwarded, so a read right behind it sees it.
            assign prio_view[gi] = (prio_we[gi] && PRESENT) ? prio_d[gi] : prio_q[gi];

            prio_field #(
                .PRESENT(PRESENT)
            ) u_field (
                .core_clk_i(core_clk_i),
                .rst_b_i(rst_b_i),
                .we_i(prio_we[gi]),
                .d_i(prio_d[gi]),
                .q_o(prio_q[gi])
            );

            source_gate u_gate (
                .core_clk_i(core_clk_i),
                .rst_b_i(rst_b_i),
                .flag_i(src_flag_i[gi]),
                .prio_i(prio_q[gi]),
                .req_o(src_req_o[gi]),
                .level_o(src_level_o[gi])
            );
        end
    endgenerate

    assign uart_rx_prio_o = prio_q[SRC_UART_RX];
    assign spi_event_prio_o = prio_q[SRC_SPI_EVENT];
    assign spi_error_prio_o = prio_q[SRC_SPI_ERROR];
    assign timer3_prio_o = prio_q[SRC_TIMER3];
    assign ext_int1_prio_o = prio_q[SRC_EXT_INT1];
    assign timer4_prio_o = prio_q[SRC_TIMER4];

    // ==========================================================
    // Read path
    always_comb begin
        next_rdata = '0;
        if (ap_hit) begin
            for (int i = 0; i < NUM_SRC; i++) begin
                if (FIELD_REG[i] == ap_idx) begin
                    next_rdata = next_rdata | (REG_W'(prio_view[i]) << FIELD_LSB[i]);
                end
            end
        end
    end

    // Read data are taken in the address phase so they stand from a flop in the data phase.
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            hrdata_o <= '0;
        end else if (addr_phase && !hwrite_i) begin
            hrdata_o <= {16'h0000, next_rdata};
        end
    end

    // ==========================================================
    // Checks
    logic [NUM_SRC-1:0] off_q;
    logic rd_a_q;
    logic rd_b_q;
    logic rd_c_q;
    logic live_q;

    // The request flops still show their reset value in the first cycle after release.
    // The live_q flag keeps the request checks quiet until that cycle has passed.
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            off_q <= '0;
            rd_a_q <= 1'b0;
            rd_b_q <= 1'b0;
            rd_c_q <= 1'b0;
            live_q <= 1'b0;
        end else begin
            for (int i = 0; i < NUM_SRC; i++) begin
                off_q[i] <= (prio_q[i] == PRIO_OFF);
            end
            rd_a_q <= addr_phase && !hwrite_i && ap_hit && ap_idx == IDX_PRIO_A;
            rd_b_q <= addr_phase && !hwrite_i && ap_hit && ap_idx == IDX_PRIO_B;
            rd_c_q <= addr_phase && !hwrite_i && ap_hit && ap_idx == IDX_PRIO_C;
            live_q <= 1'b1;
        end
    end

    AST_TOP_LEVEL: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (uart_rx_prio_o == PRIO_MAX && src_flag_i[SRC_UART_RX])
            |=> src_req_o[SRC_UART_RX] && src_level_o[SRC_UART_RX] == 3'h7)
        else $error("Priority code 111 did not give level 7.");

    AST_LOW_LEVEL: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (spi_event_prio_o == PRIO_MIN && src_flag_i[SRC_SPI_EVENT])
            |=> src_req_o[SRC_SPI_EVENT] && src_level_o[SRC_SPI_EVENT] == 3'h1)
        else $error("Priority code 001 did not give level 1.");

    AST_DISABLED_SILENT: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (src_req_o & off_q) == '0
            && (!live_q || src_req_o == ($past(src_flag_i) & ~off_q)))
        else $error("A disabled source requested, or an enabled flag was lost.");

    AST_RESERVED_ZERO: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (hrdata_o & ~32'(MASK_PRIO_A)) == '0)
        else $error("An unimplemented bit read as one.");

    AST_UART_FIELD: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (prio_we[SRC_UART_RX] && dp_idx == IDX_PRIO_A) |=> uart_rx_prio_o == $past(hwdata_i[14:12]))
        else $error("UART receive priority did not take bits 14 to 12.");

    AST_SPI_EVENT_FIELD: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        prio_we[SRC_SPI_EVENT] |=> spi_event_prio_o == $past(hwdata_i[10:8]))
        else $error("SPI event priority did not take bits 10 to 8.");

    AST_SPI_ERROR_FIELD: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        prio_we[SRC_SPI_ERROR] |=> spi_error_prio_o == $past(hwdata_i[6:4]))
        else $error("SPI error priority did not take bits 6 to 4.");

    AST_EXT_INT1_FIELD: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (prio_we[SRC_EXT_INT1] |=> ext_int1_prio_o == $past(hwdata_i[2:0]))
        and (rd_b_q |-> hrdata_o[15:3] == '0))
        else $error("External interrupt 1 field or its unused bits misbehaved.");

    AST_TIMER4_FIELD: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (prio_we[SRC_TIMER4] |=> timer4_prio_o == (HAS_TIMER4 ? $past(hwdata_i[14:12]) : 3'h0))
        and (rd_c_q |-> hrdata_o[11:0] == '0))
        else $error("Timer4 field or its unused bits misbehaved.");

    AST_RESET_VALUE: assert property (@(posedge core_clk_i)
        !rst_b_i |=> uart_rx_prio_o == 3'h4 && spi_event_prio_o == 3'h4 && spi_error_prio_o == 3'h4
            && timer3_prio_o == 3'h4 && ext_int1_prio_o == 3'h4 && timer4_prio_o == (HAS_TIMER4 ? 3'h4 : 3'h0))
        else $error("A priority field did not reset to level 4.");

    AST_TIMER3_FIELD: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        prio_we[SRC_TIMER3] |=> timer3_prio_o == $past(hwdata_i[2:0]) && $stable(ext_int1_prio_o))
        else $error("Timer3 priority did not take bits 2 to 0 of the first register.");

    AST_RESET_OUTPUTS: assert property (@(posedge core_clk_i)
        !rst_b_i |=> src_req_o == '0 && src_level_o == '0 && hrdata_o == '0)
        else $error("Requests, levels or read data were not cleared by reset.");

    // A write that misses every register must leave all fields alone.
    AST_UNMAPPED_WRITE: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (dp_valid && dp_write && !dp_hit)
            |=> $stable(uart_rx_prio_o) && $stable(spi_event_prio_o) && $stable(spi_error_prio_o)
            && $stable(timer3_prio_o) && $stable(ext_int1_prio_o) && $stable(timer4_prio_o))
        else $error("A write to an unmapped word changed a priority field.");

    AST_UNMAPPED_READ: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (addr_phase && !hwrite_i && !ap_hit) |=> hrdata_o == '0)
        else $error("A read of an unmapped word returned nonzero data.");

    // In the data phase of a read, each field must stand at its own place in the read data.
    AST_FIRST_READBACK: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        rd_a_q |-> hrdata_o[14:12] == uart_rx_prio_o && hrdata_o[10:8] == spi_event_prio_o
            && hrdata_o[6:4] == spi_error_prio_o && hrdata_o[2:0] == timer3_prio_o)
        else $error("The first priority register read back a field out of place.");

    AST_SECOND_READBACK: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        rd_b_q |-> hrdata_o[2:0] == ext_int1_prio_o)
        else $error("The second priority register read back its field out of place.");

    AST_THIRD_READBACK: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        rd_c_q |-> hrdata_o[14:12] == timer4_prio_o)
        else $error("The third priority register read back its field out of place.");

    AST_MID_LEVELS: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (ext_int1_prio_o > PRIO_MIN && ext_int1_prio_o < PRIO_MAX && src_flag_i[SRC_EXT_INT1])
            |=> src_level_o[SRC_EXT_INT1] == $past(ext_int1_prio_o))
        else $error("An intermediate priority code did not give its own level.");

    AST_TIMER4_SOURCE: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        src_flag_i[SRC_TIMER4] |=> src_req_o[SRC_TIMER4] == (HAS_TIMER4 && $past(timer4_prio_o) != PRIO_OFF))
        else $error("The timer4 source requested while absent or disabled.");

    // Each source requests at its own field code one cycle after its flag, and stays silent at code 000.
    generate
        for (gi = 0; gi < NUM_SRC; gi++) begin : g_check
            AST_SOURCE_LEVEL: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
                live_q |-> src_req_o[gi] == ($past(src_flag_i[gi]) && !off_q[gi])
                    && src_level_o[gi] == (src_req_o[gi] ? $past(prio_q[gi]) : PRIO_OFF))
                else $error("A source request or level did not follow its flag and field.");
        end
    endgenerate

endmodule

`default_nettype wire

// ### rtl/intc_prio_pkg.sv
// Shared constants and types for the interrupt priority field block.
package intc_prio_pkg;

    // ==========================================================
    // Field encoding
    localparam int PRIO_W = 3;
    typedef logic [PRIO_W-1:0] prio_t;
    localparam prio_t PRIO_OFF = 3'h0;
    localparam prio_t PRIO_MIN = 3'h1;
    localparam prio_t PRIO_MAX = 3'h7;
    localparam prio_t PRIO_RESET = 3'h4;

    // ==========================================================
    // Sources, in the order used by every per-source vector
    localparam int NUM_SRC = 6;
    localparam int SRC_UART_RX = 0;
    localparam int SRC_SPI_EVENT = 1;
    localparam int SRC_SPI_ERROR = 2;
    localparam int SRC_TIMER3 = 3;
    localparam int SRC_EXT_INT1 = 4;
    localparam int SRC_TIMER4 = 5;

    // ==========================================================
    // Register map
    localparam int HADDR_W = 12;
    localparam int REG_W = 16;
    localparam int NUM_REG = 3;
    localparam int REG_IDX_W = 2;
    typedef logic [REG_IDX_W-1:0] reg_idx_t;
    localparam reg_idx_t IDX_PRIO_A = 2'h0;
    localparam reg_idx_t IDX_PRIO_B = 2'h1;
    localparam reg_idx_t IDX_PRIO_C = 2'h2;
    localparam logic [HADDR_W-1:0] OFF_PRIORITY_UART_SPI_TIMER3 = 12'h000;
    localparam logic [HADDR_W-1:0] OFF_PRIORITY_EXTERNAL_INT1 = 12'h004;
    localparam logic [HADDR_W-1:0] OFF_PRIORITY_TIMER4 = 12'h008;
    localparam logic [REG_W-1:0] MASK_PRIO_A = 16'h7777;
    localparam logic [REG_W-1:0] MASK_PRIO_B = 16'h0007;
    localparam logic [REG_W-1:0] MASK_PRIO_C = 16'h7000;

    // Field position and home register of each source.
    localparam int FIELD_LSB [NUM_SRC] = '{12, 8, 4, 0, 0, 12};
    localparam reg_idx_t FIELD_REG [NUM_SRC] = '{IDX_PRIO_A, IDX_PRIO_A, IDX_PRIO_A, IDX_PRIO_A,
                                                IDX_PRIO_B, IDX_PRIO_C};

    // ==========================================================
    // AHB-Lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

endpackage

// ### rtl/prio_field.sv
// One software-writable priority field with its reset value.
`timescale 1ns/1ps
`default_nettype none

module prio_field #(
    parameter bit PRESENT = 1'b1
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic we_i,
    input wire intc_prio_pkg::prio_t d_i,
    output intc_prio_pkg::prio_t q_o
);
    import intc_prio_pkg::*;

    generate
        if (PRESENT) begin : g_present
            always_ff @(posedge core_clk_i) begin
                if (!rst_b_i) begin
                    q_o <= PRIO_RESET;
                end else if (we_i) begin
                    q_o <= d_i;
                end
            end
        end else begin : g_absent
            // A field missing on this variant reads as zero and drops writes.
            assign q_o = PRIO_OFF;
        end
    endgenerate

endmodule

`default_nettype wire

// ### rtl/source_gate.sv
// Gates one source flag by its priority field and registers the request.
`timescale 1ns/1ps
`default_nettype none

module source_gate (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic flag_i,
    input wire intc_prio_pkg::prio_t prio_i,
    output logic req_o,
    output intc_prio_pkg::prio_t level_o
);
    import intc_prio_pkg::*;

    logic enabled;

    assign enabled = (prio_i != PRIO_OFF);

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            req_o <= 1'b0;
            level_o <= PRIO_OFF;
        end else begin
            req_o <= flag_i && enabled;
            // The field code is the level itself, 1 lowest through 7 highest.
            level_o <= (flag_i && enabled) ? prio_i : PRIO_OFF;
        end
    end

endmodule

`default_nettype wire

// ### tb/intc_prio_regs_tb.sv
// Self-checking testbench for the interrupt priority register block.
`timescale 1ns/1ps
`default_nettype none

module intc_prio_regs_tb;
    import intc_prio_pkg::*;

    // ==========================================================
    // Signals and behavioural model
    logic core_clk_i;
    logic rst_b_i;
    logic hsel_i;
    logic [HADDR_W-1:0] haddr_i;
    logic [1:0] htrans_i;
    logic hwrite_i;
    logic [2:0] hsize_i;
    logic [31:0] hwdata_i;
    logic [31:0] hrdata_o;
    logic hreadyout_o;
    logic hresp_o;
    logic [NUM_SRC-1:0] src_flag_i;
    logic [NUM_SRC-1:0] src_req_o;
    prio_t [NUM_SRC-1:0] src_level_o;
    prio_t prio_seen [NUM_SRC];
    int err_count;
    int samples_checked;
    int mdl [3];
    int mdl_mask [3] = '{32'h7777, 32'h0007, 32'h7000};
    int mdl_reg [NUM_SRC] = '{0, 0, 0, 0, 1, 2};
    int mdl_lsb [NUM_SRC] = '{12, 8, 4, 0, 0, 12};
    logic [HADDR_W-1:0] reg_addr [4];
    logic [31:0] rd;

    intc_prio_regs u_intc_prio_regs (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .hsel_i(hsel_i),
        .haddr_i(haddr_i),
        .htrans_i(htrans_i),
        .hwrite_i(hwrite_i),
        .hsize_i(hsize_i),
        .hwdata_i(hwdata_i),
        .hready_i(hreadyout_o),
        .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_o),
        .src_flag_i(src_flag_i),
        .src_req_o(src_req_o),
        .src_level_o(src_level_o),
        .uart_rx_prio_o(prio_seen[0]),
        .spi_event_prio_o(prio_seen[1]),
        .spi_error_prio_o(prio_seen[2]),
        .timer3_prio_o(prio_seen[3]),
        .ext_int1_prio_o(prio_seen[4]),
        .timer4_prio_o(prio_seen[5])
    );

    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end

    // ==========================================================
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (err_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Single transfer; waits on hready in both phases, bounded by the watchdog.
    task automatic ahb_xfer(input logic wr, input int r, input logic [31:0] wdata);
        hsel_i <= 1'b1;
        haddr_i <= reg_addr[r];
        hwrite_i <= wr;
        htrans_i <= HTRANS_NONSEQ;
        do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
        htrans_i <= 2'h0;
        hwdata_i <= wdata;
        do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
        rd = hrdata_o;
        if (wr && r < 3) begin
            mdl[r] = wdata & mdl_mask[r];
        end
    endtask

    task automatic reset_model();
        for (int r = 0; r < 3; r++) begin
            mdl[r] = 32'h4444 & mdl_mask[r];
        end
    endtask

    // Field outputs against the model, 1 ns after the call; then waits one clock edge.
    task automatic check_outs();
        #1;
        for (int i = 0; i < NUM_SRC; i++) begin
            check(32'(prio_seen[i]), (mdl[mdl_reg[i]] >> mdl_lsb[i]) & 7);
        end
        @(posedge core_clk_i);
    endtask

    task automatic read_all();
        for (int r = 0; r < 3; r++) begin
            ahb_xfer(1'b0, r, 32'h0);
            check(rd, mdl[r]);
            check(32'(hresp_o), 32'(HRESP_OKAY));
        end
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        logic [NUM_SRC-1:0] f;
        int r;
        rst_b_i = 1'b0;
        hsel_i = 1'b0;
        haddr_i = '0;
        htrans_i = 2'h0;
        hwrite_i = 1'b0;
        hsize_i = 3'h2;
        hwdata_i = '0;
        src_flag_i = '0;
        err_count = 0;
        samples_checked = 0;
        // The fourth address is an unmapped word just past the map.
        reg_addr = '{OFF_PRIORITY_UART_SPI_TIMER3, OFF_PRIORITY_EXTERNAL_INT1, OFF_PRIORITY_TIMER4, 12'h00c};
        void'($urandom(8));
        reset_model();
        repeat (3) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        read_all();
        check_outs();
        // Unmapped word: writes vanish and reads give zero.
        ahb_xfer(1'b1, 3, 32'hffffffff);
        ahb_xfer(1'b0, 3, 32'h0);
        check(rd, 32'h0);
        read_all();
        for (int k = 0; k < 24; k++) begin
            r = $urandom_range(0, 2);
            ahb_xfer(1'b1, r, $urandom);
            ahb_xfer(1'b0, r, 32'h0);
            check(rd, mdl[r]);
            check_outs();
        end
        // Every code on every source, with random flag patterns.
        for (int code = 0; code < 8; code++) begin
            ahb_xfer(1'b1, 0, {16'h0, {4{1'b0, 3'(code)}}});
            ahb_xfer(1'b1, 1, 32'(code));
            ahb_xfer(1'b1, 2, 32'(code) << 12);
            for (int k = 0; k < 4; k++) begin
                f = NUM_SRC'($urandom);
                src_flag_i <= f;
                @(posedge core_clk_i);
                #1;
                for (int i = 0; i < NUM_SRC; i++) begin
                    check(32'({src_req_o[i], src_level_o[i]}), (f[i] && code != 0) ? 8 + code : 0);
                end
                @(posedge core_clk_i);
            end
        end
        rst_b_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        reset_model();
        read_all();
        check_outs();
        tally_and_finish();
    end

    initial begin
        repeat (20000) @(posedge core_clk_i);
        err_count++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
